// file: include/scb_pkg.sv
// constants and types shared by the slot configuration register bank
package scb_pkg;

    // setup-select register offsets
    localparam logic [2:0] OFF_IDENT_LOW  = 3'h0;
    localparam logic [2:0] OFF_IDENT_HIGH = 3'h1;
    localparam logic [2:0] OFF_IRQ_ROM    = 3'h2;
    localparam logic [2:0] OFF_SUB_DATA   = 3'h3;
    localparam logic [2:0] OFF_MEM_WIN    = 3'h4;
    localparam logic [2:0] OFF_CHK_IOBASE = 3'h5;
    localparam logic [2:0] OFF_ERR_SUBLO  = 3'h6;
    localparam logic [2:0] OFF_SUB_HIGH   = 3'h7;

    localparam logic [15:0] SUB_MASTER_OPTS = 16'h0000;

    // values after channel reset
    localparam logic [7:0] RST_IRQ_ROM    = 8'h12;
    localparam logic [7:0] RST_MEM_WIN    = 8'h00;
    localparam logic [7:0] RST_CHK_IOBASE = 8'hC0;
    localparam logic [7:0] RST_ERR_SUBLO  = 8'h00;
    localparam logic [7:0] RST_SUB_HIGH   = 8'h00;
    localparam logic [7:0] RST_MASTER_OPT = 8'h1C;
    localparam logic [15:0] IDENT_BLANK   = 16'h0000;
    // arbitrary identification value, not taken from any product
    localparam logic [15:0] IDENT_DEFAULT = 16'h5A3C;

    // field positions
    localparam int IRQ_LSB     = 6;
    localparam int ROM_LSB     = 2;
    localparam int ROM_SIZE_B  = 1;
    localparam int CARD_EN_B   = 0;
    localparam int CHK_FLAG_B  = 7;
    localparam int STAT_VAL_B  = 6;
    localparam int IOBASE_LSB  = 3;
    localparam int MEMHI_LSB   = 5;
    localparam int MEMLO_LSB   = 1;
    localparam int CHK_EN_B    = 0;

    localparam logic [3:0]  ROM_OFF_CODE   = 4'h4;
    localparam logic [19:0] ROM_BASE_ADDR  = 20'hC0000;
    localparam int          ROM_STEP_SHIFT = 13;
    localparam logic [3:0]  IRQ_LEVEL_BASE = 4'h9;
    localparam logic [2:0]  WIN_SIZE_CODE  = 3'h0;

    // timing
    localparam int CLK_PERIOD_NS      = 8;
    localparam int READY_TIMEOUT_NS   = 3000;
    localparam int READY_TIMEOUT_CYC  =
        (READY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint IDENT_DEADLINE_NS = 64'd1000000000;
    localparam int IDENT_DEADLINE_CYC =
        int'(IDENT_DEADLINE_NS / CLK_PERIOD_NS);

    typedef enum logic [0:0] {
        SCB_IDENT_WAIT  = 1'b0,
        SCB_IDENT_READY = 1'b1
    } scb_ident_type;

    // slave error events, one-cycle pulses, bit order as the status byte
    typedef struct packed {
        logic basic_parity;
        logic stream_parity;
        logic extra_strobe_err;
        logic ready_timeout;
        logic byte_lane_bad;
    } scb_err_type;

    typedef struct packed {
        logic       stream_enable;
        logic       feedback_check_enable;
        logic       parity_enable;
        logic       chan_err_async_sel;
        logic [3:0] arb_level;
    } scb_master_opts_type;

endpackage

// file: rtl/scb_bank.sv
// slot configuration register bank reached by setup-select cycles
`timescale 1ns/1ns
`default_nettype none

module scb_bank
    import scb_pkg::*;
#(
    parameter int IDENT_DEADLINE = scb_pkg::IDENT_DEADLINE_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       setup_select_n,
    input  wire logic [2:0]                 cfg_addr,
    input  wire logic                       cfg_wr,
    input  wire logic                       cfg_rd,
    input  wire logic [7:0]                 cfg_wdata,
    output logic      [7:0]                 cfg_rdata,
    input  wire logic                       selftest_done,
    input  wire logic                       host_access_req,
    output logic                            host_access_accept,
    input  wire scb_pkg::scb_err_type       slave_err,
    input  wire logic                       slave_ready,
    input  wire logic                       bus_cycle_end,
    input  wire logic                       bus_master_active,
    input  wire logic                       select_feedback_ret_n,
    output logic                            feedback_err,
    output logic                            chan_error_n,
    output logic                            addr_par_en_n,
    output logic                            data_par_en_n,
    output logic                            ident_valid,
    output logic      [3:0]                 irq_level,
    output logic                            rom_window_en,
    output logic      [19:0]                rom_window_base,
    output logic                            rom_window_size,
    output logic      [2:0]                 mem_win_high,
    output logic      [3:0]                 mem_win_low,
    output logic      [2:0]                 io_base_high,
    output scb_pkg::scb_master_opts_type    master_opts
);
    import scb_pkg::*;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        return a == o;
    endfunction

    scb_ident_type       ident_state_reg;
    logic [26:0]         ident_cnt_reg;
    logic [7:0]          irq_rom_reg;
    logic [7:0]          mem_win_reg;
    logic [7:0]          chk_iobase_reg;
    logic [7:0]          err_sublo_reg;
    logic [7:0]          sub_high_reg;
    scb_master_opts_type opts_reg;
    logic [4:0]          err_pend_reg;
    logic [8:0]          ready_cnt_reg;
    logic                ready_to_reg;

    // decode of setup-select cycles
    wire setup_act = !setup_select_n;
    wire wr_en     = setup_act && cfg_wr;
    wire rd_en     = setup_act && cfg_rd;
    wire wr_rom    = wr_en && hit(cfg_addr, OFF_IRQ_ROM);
    wire wr_sub    = wr_en && hit(cfg_addr, OFF_SUB_DATA);
    wire wr_mem    = wr_en && hit(cfg_addr, OFF_MEM_WIN);
    wire wr_chk    = wr_en && hit(cfg_addr, OFF_CHK_IOBASE);
    wire wr_lo     = wr_en && hit(cfg_addr, OFF_ERR_SUBLO);
    wire wr_hi     = wr_en && hit(cfg_addr, OFF_SUB_HIGH);
    wire [15:0] sub_addr = {sub_high_reg, err_sublo_reg};
    wire sub_opts  = sub_addr == SUB_MASTER_OPTS;
    wire chk_raised = !chk_iobase_reg[CHK_FLAG_B];

    // ident counts up to its deadline independent of firmware
    wire ident_go = selftest_done ||
                    ident_cnt_reg >= 27'(IDENT_DEADLINE - 1);
    wire [15:0] ident_word = (ident_state_reg == SCB_IDENT_READY)
                             ? IDENT_DEFAULT : IDENT_BLANK;

    // error events, parity ones gated by parity enable, rest by check enable
    wire [4:0] err_raw = slave_err | {3'h0, ready_to_reg, 1'b0} ;
    wire [4:0] err_mask = {{2{opts_reg.parity_enable}},
                           {3{mem_win_reg[CHK_EN_B]}}};
    wire [4:0] err_new = err_raw & err_mask;
    wire [4:0] err_all = err_pend_reg | err_new;
    // sync mode waits for the cycle end; chan_error_n falls two cycles after it
    wire raise = (err_all != 5'h00) && !chk_raised &&
                 (opts_reg.chan_err_async_sel || bus_cycle_end);
    wire host_clear = wr_chk && cfg_wdata[CHK_FLAG_B];

    wire ready_to_hit = ready_cnt_reg >= 9'(READY_TIMEOUT_CYC);

    wire [7:0] chk_wr_val = {chk_iobase_reg[CHK_FLAG_B],
                             chk_iobase_reg[STAT_VAL_B],
                             cfg_wdata[IOBASE_LSB +: 3],
                             WIN_SIZE_CODE};
    wire [7:0] chk_next_flags =
        raise      ? {1'b0, 1'b0, chk_iobase_reg[5:0]} :
        host_clear ? {1'b1, 1'b1, chk_iobase_reg[5:0]} :
                     chk_iobase_reg;
    wire [7:0] chk_next = {chk_next_flags[7:6],
                           wr_chk ? chk_wr_val[5:0]
                                  : chk_iobase_reg[5:0]};

    // status overrides the subaddress byte in the cycle a check is raised
    wire [7:0] lo_next = raise ? {3'h0, err_all} :
                         wr_lo ? cfg_wdata : err_sublo_reg;

    logic [7:0] rd_mux;
    always_comb begin
        unique case (cfg_addr)
            OFF_IDENT_LOW:  rd_mux = ident_word[7:0];
            OFF_IDENT_HIGH: rd_mux = ident_word[15:8];
            OFF_IRQ_ROM:    rd_mux = irq_rom_reg;
            OFF_SUB_DATA:   rd_mux = sub_opts ? opts_reg : 8'h00;
            OFF_MEM_WIN:    rd_mux = mem_win_reg;
            OFF_CHK_IOBASE: rd_mux = chk_iobase_reg;
            OFF_ERR_SUBLO:  rd_mux = err_sublo_reg;
            OFF_SUB_HIGH:   rd_mux = sub_high_reg;
        endcase
    end

    wire [3:0]  rom_code = irq_rom_reg[ROM_LSB +: 4];
    wire [19:0] rom_next = ROM_BASE_ADDR +
                           (20'(rom_code) << ROM_STEP_SHIFT);

    // identification state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ident_state_reg <= SCB_IDENT_WAIT;
            ident_cnt_reg   <= 27'h0;
        end else begin
            if (ident_state_reg == SCB_IDENT_WAIT) begin
                ident_cnt_reg <= ident_cnt_reg + 27'h1;
                if (ident_go) begin
                    ident_state_reg <= SCB_IDENT_READY;
                end
            end
        end
    end

    // configuration registers, only channel reset clears them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_rom_reg    <= RST_IRQ_ROM;
            mem_win_reg    <= RST_MEM_WIN;
            chk_iobase_reg <= RST_CHK_IOBASE;
            err_sublo_reg  <= RST_ERR_SUBLO;
            sub_high_reg   <= RST_SUB_HIGH;
            opts_reg       <= RST_MASTER_OPT;
        end else begin
            if (wr_rom) begin
                irq_rom_reg <= cfg_wdata;
            end
            if (wr_mem) begin
                mem_win_reg <= cfg_wdata;
            end
            if (wr_hi) begin
                sub_high_reg <= cfg_wdata;
            end
            if (wr_sub && sub_opts) begin
                opts_reg <= cfg_wdata;
            end
            chk_iobase_reg <= chk_next;
            err_sublo_reg  <= lo_next;
        end
    end

    // pending errors and ready timeout
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_pend_reg  <= 5'h00;
            ready_cnt_reg <= 9'h000;
            ready_to_reg  <= 1'b0;
        end else begin
            err_pend_reg <= raise ? 5'h00 : err_all;
            ready_to_reg <= ready_to_hit && !ready_to_reg &&
                            ready_cnt_reg == 9'(READY_TIMEOUT_CYC);
            if (slave_ready) begin
                ready_cnt_reg <= 9'h000;
            end else if (!ready_to_hit) begin
                ready_cnt_reg <= ready_cnt_reg + 9'h001;
            end else if (ready_cnt_reg == 9'(READY_TIMEOUT_CYC)) begin
                ready_cnt_reg <= ready_cnt_reg + 9'h001;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata          <= 8'h00;
            host_access_accept <= 1'b0;
            feedback_err       <= 1'b0;
            chan_error_n       <= 1'b1;
            addr_par_en_n      <= 1'b1;
            data_par_en_n      <= 1'b1;
            ident_valid        <= 1'b0;
            irq_level          <= IRQ_LEVEL_BASE;
            rom_window_en      <= 1'b0;
            rom_window_base    <= ROM_BASE_ADDR;
            rom_window_size    <= 1'b0;
            mem_win_high       <= 3'h0;
            mem_win_low        <= 4'h0;
            io_base_high       <= 3'h0;
            master_opts        <= RST_MASTER_OPT;
        end else begin
            if (rd_en) begin
                cfg_rdata <= rd_mux;
            end
            host_access_accept <= host_access_req &&
                                  irq_rom_reg[CARD_EN_B];
            feedback_err <= bus_master_active &&
                            opts_reg.feedback_check_enable &&
                            select_feedback_ret_n;
            chan_error_n  <= chk_iobase_reg[CHK_FLAG_B];
            addr_par_en_n <= !(bus_master_active &&
                               opts_reg.parity_enable);
            data_par_en_n <= !(bus_master_active &&
                               opts_reg.parity_enable);
            ident_valid   <= ident_state_reg == SCB_IDENT_READY;
            irq_level     <= IRQ_LEVEL_BASE +
                             4'(irq_rom_reg[IRQ_LSB +: 2]);
            rom_window_en   <= rom_code != ROM_OFF_CODE;
            rom_window_base <= rom_next;
            rom_window_size <= irq_rom_reg[ROM_SIZE_B];
            mem_win_high  <= mem_win_reg[MEMHI_LSB +: 3];
            mem_win_low   <= mem_win_reg[MEMLO_LSB +: 4];
            io_base_high  <= chk_iobase_reg[IOBASE_LSB +: 3];
            master_opts   <= opts_reg;
        end
    end

    // checks
    card_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        host_access_req && !irq_rom_reg[CARD_EN_B] |=> !host_access_accept)
        else $error("access accepted while card disabled");

    rom_off_a: assert property (@(posedge clk) disable iff (!resetn)
        rom_code == ROM_OFF_CODE |=> !rom_window_en)
        else $error("rom window on with disable code");

    irq_map_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_rom_reg[7:6] == 2'b11 |=> irq_level == 4'hC)
        else $error("irq level code 11 not level 12");

    win_size_a: assert property (@(posedge clk) disable iff (!resetn)
        chk_iobase_reg[2:0] == WIN_SIZE_CODE)
        else $error("window size field changed");

    chk_raise_a: assert property (@(posedge clk) disable iff (!resetn)
        raise |=> !chk_iobase_reg[CHK_FLAG_B] && !chk_iobase_reg[STAT_VAL_B]
                  ##1 !chan_error_n)
        else $error("channel check not raised");

    chk_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        host_clear && !raise |=> chk_iobase_reg[7:6] == 2'b11)
        else $error("host clear did not restore flags");

    status_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        chk_raised && $fell(chk_iobase_reg[CHK_FLAG_B])
        |-> err_sublo_reg[7:5] == 3'h0 && err_sublo_reg[4:0] != 5'h00)
        else $error("status byte malformed");

    sync_mode_a: assert property (@(posedge clk) disable iff (!resetn)
        !opts_reg.chan_err_async_sel && !bus_cycle_end |=> !$fell(
            chk_iobase_reg[CHK_FLAG_B]))
        else $error("sync check raised off cycle end");

    ready_to_a: assert property (@(posedge clk) disable iff (!resetn)
        ready_to_reg |-> $past(ready_cnt_reg) == 9'(READY_TIMEOUT_CYC))
        else $error("ready timeout at wrong count");

    ident_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && hit(cfg_addr, OFF_IDENT_LOW) &&
        ident_state_reg == SCB_IDENT_WAIT |=> cfg_rdata == IDENT_BLANK[7:0])
        else $error("ident not blank before self-test");

    par_en_a: assert property (@(posedge clk) disable iff (!resetn)
        bus_master_active && opts_reg.parity_enable
        |=> !addr_par_en_n && !data_par_en_n)
        else $error("parity enables not driven as master");

    ident_up_a: assert property (@(posedge clk) disable iff (!resetn)
        selftest_done |=> ##1 ident_valid)
        else $error("ident not valid after self-test");

    sub_rd_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && hit(cfg_addr, OFF_SUB_DATA) && sub_opts
        |=> cfg_rdata == $past(opts_reg))
        else $error("subaddress zero read wrong");

    sub_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && hit(cfg_addr, OFF_SUB_DATA) && !sub_opts
        |=> cfg_rdata == 8'h00)
        else $error("other subaddress read not zero");

    sub_wr_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_sub && !sub_opts |=> $stable(opts_reg))
        else $error("options written through other subaddress");

    stat_ro_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_chk && !raise && !host_clear
        |=> chk_iobase_reg[7:6] == $past(chk_iobase_reg[7:6]))
        else $error("check flags moved by plain write");

    iobase_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_chk |=> ##1 io_base_high == $past(cfg_wdata[IOBASE_LSB +: 3], 2))
        else $error("io base bits not taken from write");

    mem_win_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_mem |=> ##1 mem_win_high == $past(cfg_wdata[MEMHI_LSB +: 3], 2)
                   && mem_win_low == $past(cfg_wdata[MEMLO_LSB +: 4], 2))
        else $error("memory window bits not taken from write");

    rom_top_a: assert property (@(posedge clk) disable iff (!resetn)
        rom_code == 4'hF |=> rom_window_base == 20'hDE000)
        else $error("rom window top address wrong");

    rom_size_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_rom_reg[ROM_SIZE_B] |=> rom_window_size)
        else $error("rom window size not 16 KB");

    irq_low_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_rom_reg[IRQ_LSB +: 2] == 2'b00 |=> irq_level == 4'h9)
        else $error("irq level code 00 not level 9");

    card_on_a: assert property (@(posedge clk) disable iff (!resetn)
        host_access_req && irq_rom_reg[CARD_EN_B] |=> host_access_accept)
        else $error("access refused while card enabled");

    chk_mask_a: assert property (@(posedge clk) disable iff (!resetn)
        !mem_win_reg[CHK_EN_B] && err_pend_reg == 5'h00 && !chk_raised &&
        slave_err[4:3] == 2'b00 |=> chk_iobase_reg[CHK_FLAG_B])
        else $error("channel check raised while disabled");

    chk_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        chk_raised && !host_clear |=> chk_raised)
        else $error("channel check dropped without host clear");

    ready_rst_a: assert property (@(posedge clk) disable iff (!resetn)
        slave_ready |=> ready_cnt_reg == 9'h000)
        else $error("ready counter not cleared");

    feedback_a: assert property (@(posedge clk) disable iff (!resetn)
        bus_master_active && opts_reg.feedback_check_enable &&
        select_feedback_ret_n |=> feedback_err)
        else $error("missing feedback return not flagged");

    par_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !bus_master_active |=> addr_par_en_n && data_par_en_n)
        else $error("parity enables driven while not master");

endmodule // scb_bank

`default_nettype wire

// file: dv/scb_host_model.sv
// host setup-select bus model driving the configuration bank
`timescale 1ns/1ns
`default_nettype none
module scb_host_model (
    input  wire logic       clk,
    output logic            setup_select_n,
    output logic [2:0]      cfg_addr,
    output logic            cfg_wr,
    output logic            cfg_rd,
    output logic [7:0]      cfg_wdata,
    input  wire logic [7:0] cfg_rdata
);
    initial begin
        setup_select_n = 1'b1;
        cfg_addr = 3'h5;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_wdata = 8'hA5;
    end
    // one access per call; released lines flip so stale values never match
    task automatic xfer(input logic w, input logic [2:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        #1;
        setup_select_n = 1'b0;
        cfg_addr = a;
        cfg_wr = w;
        cfg_rd = !w;
        cfg_wdata = d;
        @(posedge clk);
        #1;
        setup_select_n = 1'b1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~d;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        @(posedge clk);
        #1;
        d = cfg_rdata;
    endtask
endmodule // scb_host_model
`default_nettype wire

// file: dv/scb_bank_tb.sv
// self-checking bench for the slot configuration register bank
`timescale 1ns/1ns
`default_nettype none
module scb_bank_tb;
    import scb_pkg::*;
    logic clk, resetn, setup_select_n, cfg_wr, cfg_rd, selftest_done;
    logic [2:0] cfg_addr, mem_win_high, io_base_high;
    logic [7:0] cfg_wdata, cfg_rdata, v;
    logic host_access_req, host_access_accept, slave_ready, bus_cycle_end;
    logic bus_master_active, select_feedback_ret_n, feedback_err;
    logic chan_error_n, addr_par_en_n, data_par_en_n, ident_valid;
    logic [3:0] irq_level, mem_win_low;
    logic rom_window_en, rom_window_size;
    logic [19:0] rom_window_base;
    scb_err_type slave_err;
    scb_master_opts_type master_opts;
    int n_fail = 0;
    int num_checks = 0;
    int i;
    logic [7:0] rst_tab [2:7] = '{8'h12, 8'h1C, 8'h00, 8'hC0, 8'h00, 8'h00};

    scb_host_model host (.clk(clk), .setup_select_n(setup_select_n),
        .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
    // short deadline keeps the run small; self-test pulse comes first
    scb_bank #(.IDENT_DEADLINE(5000)) dut (.clk(clk), .resetn(resetn),
        .setup_select_n(setup_select_n), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .selftest_done(selftest_done),
        .host_access_req(host_access_req),
        .host_access_accept(host_access_accept), .slave_err(slave_err),
        .slave_ready(slave_ready), .bus_cycle_end(bus_cycle_end),
        .bus_master_active(bus_master_active),
        .select_feedback_ret_n(select_feedback_ret_n),
        .feedback_err(feedback_err), .chan_error_n(chan_error_n),
        .addr_par_en_n(addr_par_en_n), .data_par_en_n(data_par_en_n),
        .ident_valid(ident_valid), .irq_level(irq_level),
        .rom_window_en(rom_window_en), .rom_window_base(rom_window_base),
        .rom_window_size(rom_window_size), .mem_win_high(mem_win_high),
        .mem_win_low(mem_win_low), .io_base_high(io_base_high),
        .master_opts(master_opts));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [19:0] e,
                       input logic [19:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk("cfg_rdata", {12'h000, e}, {12'h000, v});
    endtask
    task automatic pulse_err(input logic [4:0] b);
        tick(1);
        slave_err = b;
        tick(1);
        slave_err = '0;
    endtask
    task automatic clr();
        host.wr(OFF_CHK_IOBASE, 8'hB8);
        host.wr(OFF_ERR_SUBLO, 8'h00);
        tick(2);
    endtask
    task automatic boot();
        resetn = 1'b0;
        tick(4);
        resetn = 1'b1;
        rchk(OFF_IDENT_LOW, 8'h00);
        selftest_done = 1'b1;
        tick(1);
        selftest_done = 1'b0;
        // host waits for a valid ident before anything else
        for (i = 0; i < 100 && ident_valid !== 1'b1; i++) tick(1);
        chk("ident_valid", 20'h1, {19'h0, ident_valid});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial begin
        {selftest_done, host_access_req, bus_cycle_end} = 3'b000;
        {bus_master_active, select_feedback_ret_n} = 2'b01;
        slave_ready = 1'b1;
        slave_err = '0;
        boot();
        rchk(OFF_IDENT_LOW, IDENT_DEFAULT[7:0]);
        rchk(OFF_IDENT_HIGH, IDENT_DEFAULT[15:8]);
        host.wr(OFF_IDENT_LOW, 8'hFF);
        rchk(OFF_IDENT_LOW, IDENT_DEFAULT[7:0]);
        for (i = 2; i < 8; i++) rchk(3'(i), rst_tab[i]);
        chk("rom_window_en", 20'h0, {19'h0, rom_window_en});
        // odd rom codes keep the 8 KB size, as the host must
        for (i = 0; i < 16; i++) begin
            host.wr(OFF_IRQ_ROM, {i[1:0], i[3:0], ~i[0], 1'b1});
            tick(2);
            chk("irq_level", 20'(IRQ_LEVEL_BASE + 4'(i % 4)), 20'(irq_level));
            chk("rom_base", ROM_BASE_ADDR + (20'(i) << 13), rom_window_base);
            chk("rom_en", 20'(i != 4), 20'(rom_window_en));
            chk("rom_size", {19'h0, !i[0]}, 20'(rom_window_size));
        end
        host_access_req = 1'b1;
        tick(2);
        chk("accept", 20'h1, 20'(host_access_accept));
        host.wr(OFF_IRQ_ROM, 8'h12);
        tick(2);
        chk("accept", 20'h0, 20'(host_access_accept));
        rchk(OFF_IRQ_ROM, 8'h12);
        host_access_req = 1'b0;
        host.wr(OFF_SUB_DATA, 8'hA5);
        rchk(OFF_SUB_DATA, 8'hA5);
        chk("arb_level", 20'h5, 20'(master_opts.arb_level));
        chk("stream_en", 20'h1, 20'(master_opts.stream_enable));
        host.wr(OFF_ERR_SUBLO, 8'h01);
        rchk(OFF_SUB_DATA, 8'h00);
        host.wr(OFF_ERR_SUBLO, 8'h00);
        host.wr(OFF_SUB_HIGH, 8'h01);
        host.wr(OFF_SUB_DATA, 8'h11);
        host.wr(OFF_SUB_HIGH, 8'h00);
        rchk(OFF_SUB_DATA, 8'hA5);
        bus_master_active = 1'b1;
        host.wr(OFF_SUB_DATA, 8'h20);
        tick(2);
        chk("par_en_n", 20'h0, {18'h0, addr_par_en_n, data_par_en_n});
        host.wr(OFF_SUB_DATA, 8'h40);
        tick(2);
        chk("feedback_err", 20'h1, 20'(feedback_err));
        select_feedback_ret_n = 1'b0;
        tick(2);
        chk("feedback_err", 20'h0, 20'(feedback_err));
        bus_master_active = 1'b0;
        host.wr(OFF_MEM_WIN, 8'hB5);
        host.wr(OFF_CHK_IOBASE, 8'h3F);
        tick(2);
        chk("mem_win", 20'h5A, {13'h0, mem_win_high, mem_win_low});
        chk("io_base_high", 20'h7, 20'(io_base_high));
        rchk(OFF_CHK_IOBASE, 8'hF8);
        host.wr(OFF_SUB_DATA, 8'h30);
        for (i = 0; i < 5; i++) begin
            pulse_err(5'(1 << i));
            tick(3);
            chk("chan_error_n", 20'h0, 20'(chan_error_n));
            rchk(OFF_CHK_IOBASE, 8'h38);
            rchk(OFF_ERR_SUBLO, 8'(1 << i));
            host.wr(OFF_CHK_IOBASE, 8'h38);
            tick(2);
            chk("chan_error_n", 20'h0, 20'(chan_error_n));
            clr();
            chk("chan_error_n", 20'h1, 20'(chan_error_n));
            rchk(OFF_CHK_IOBASE, 8'hF8);
        end
        host.wr(OFF_MEM_WIN, 8'hB4);
        pulse_err(5'h04);
        tick(3);
        chk("chan_error_n", 20'h1, 20'(chan_error_n));
        host.wr(OFF_MEM_WIN, 8'hB5);
        slave_ready = 1'b0;
        tick(370);
        chk("chan_error_n", 20'h1, 20'(chan_error_n));
        tick(10);
        slave_ready = 1'b1;
        chk("chan_error_n", 20'h0, 20'(chan_error_n));
        rchk(OFF_ERR_SUBLO, 8'h02);
        clr();
        host.wr(OFF_SUB_DATA, 8'h20);
        pulse_err(5'h10);
        tick(3);
        chk("chan_error_n", 20'h1, 20'(chan_error_n));
        bus_cycle_end = 1'b1;
        tick(1);
        bus_cycle_end = 1'b0;
        tick(3);
        chk("chan_error_n", 20'h0, 20'(chan_error_n));
        rchk(OFF_ERR_SUBLO, 8'h10);
        clr();
        boot();
        rchk(OFF_MEM_WIN, 8'h00);
        rchk(OFF_SUB_DATA, 8'h1C);
        stop_test();
    end
endmodule // scb_bank_tb
`default_nettype wire
